/* src/edge_event_defs.svh */
// Register offsets, field layout, reset values and constants of the controller
`ifndef EDGE_EVENT_DEFS_SVH
`define EDGE_EVENT_DEFS_SVH
`define LINE_COUNT 18
`define LINE_MSB 17
`define OFF_INT_MASK 5'h00
`define OFF_EVT_MASK 5'h04
`define OFF_RISE_SEL 5'h08
`define OFF_FALL_SEL 5'h0C
`define OFF_SW_TRIG 5'h10
`define OFF_PENDING 5'h14
`define OFF_IRQ_STATUS 5'h18
`define OFF_IRQ_MASK 5'h1C
`define RST_LINES 18'h00000
`define RST_STATUS 2'h0
`define STAT_PEND_BIT 0
`define STAT_EDGE_BIT 1
`define UNMAPPED_DATA 32'h00000000
`endif

/* src/edge_event_pkg.sv */
// Types shared by the edge and event line controller files
package edge_event_pkg;
  typedef logic [17:0] lines_t;
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bus_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
    logic readdatavalid;
  } bus_rsp_s;
  typedef enum logic [1:0] {ST_IDLE, ST_DONE} bus_state_e;
endpackage : edge_event_pkg

/* src/line_sampler.sv */
// Input line synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module line_sampler (
  input wire logic clk,
  input wire logic rst,
  input wire edge_event_pkg::lines_t lines_in,
  output edge_event_pkg::lines_t rise_out,
  output edge_event_pkg::lines_t fall_out
);
  edge_event_pkg::lines_t meta_ff;
  edge_event_pkg::lines_t sync_ff;
  edge_event_pkg::lines_t prev_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= lines_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign rise_out = sync_ff & ~prev_ff;
  assign fall_out = ~sync_ff & prev_ff;
endmodule : line_sampler

/* src/avalon_slave_port.sv */
// Avalon-MM slave handshake with one wait state per access
`timescale 1ns/1ps
module avalon_slave_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic access_pulse
);
  edge_event_pkg::bus_state_e state_ff;
  edge_event_pkg::bus_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      edge_event_pkg::ST_IDLE: begin
        if (read || write) begin
          nxt_state = edge_event_pkg::ST_DONE;
        end
      end
      edge_event_pkg::ST_DONE: nxt_state = edge_event_pkg::ST_IDLE;
      default: nxt_state = edge_event_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= edge_event_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Request completes in the cycle after it is first seen
  assign access_pulse = (state_ff == edge_event_pkg::ST_DONE) &&
                        (read || write);
  assign waitrequest = (read || write) && !access_pulse;
endmodule : avalon_slave_port

/* src/edge_event_line_controller.sv */
// Eighteen-line edge triggered interrupt and event controller
//
// Contract
// - Writing one to clear trigger bit sets pending
// - Software pending interrupts only when both masks allow; irq via the status pending bit needs only the interrupt mask
// - Clearing pending also clears the trigger bit
// - Selected edge sets pending; otherwise reads zero
// - Write one or edge config change clears pending
// - Bits above seventeen read zero
// - Pending register at 0x14, bits 17 to 0
// - Eight registers 0x00 to 0x1C; all eight reset zero
// - Interrupt mask zero blocks the line request
// - Event mask zero blocks the line event
// - Edge select bits arm rising or falling edges
// - Both selects set: either edge triggers
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "edge_event_defs.svh"
module edge_event_line_controller (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire edge_event_pkg::lines_t line_in,
  output edge_event_pkg::lines_t line_irq,
  output edge_event_pkg::lines_t event_pulse,
  output logic irq
);
  edge_event_pkg::bus_req_s req;
  edge_event_pkg::lines_t int_mask_ff;
  edge_event_pkg::lines_t evt_mask_ff;
  edge_event_pkg::lines_t rise_sel_ff;
  edge_event_pkg::lines_t fall_sel_ff;
  edge_event_pkg::lines_t sw_trig_ff;
  edge_event_pkg::lines_t pending_ff;
  edge_event_pkg::lines_t event_ff;
  edge_event_pkg::lines_t line_irq_ff;
  edge_event_pkg::lines_t rise_det;
  edge_event_pkg::lines_t fall_det;
  edge_event_pkg::lines_t hw_trig;
  edge_event_pkg::lines_t sw_set;
  edge_event_pkg::lines_t pend_clr;
  edge_event_pkg::lines_t sens_chg;
  edge_event_pkg::lines_t nxt_pending;
  edge_event_pkg::lines_t nxt_rise;
  edge_event_pkg::lines_t nxt_fall;
  logic [1:0] stat_ff;
  logic [1:0] stat_mask_ff;
  logic [31:0] readdata_ff;
  logic access_pulse;
  logic wr_hit;
  logic rd_hit;

  // Byte lanes merge into an eighteen bit line field
  function automatic edge_event_pkg::lines_t merge_lanes(
    input edge_event_pkg::lines_t old_val,
    input logic [31:0] data,
    input logic [3:0] be
  );
    edge_event_pkg::lines_t res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = data[7:0];
    end
    if (be[1]) begin
      res[15:8] = data[15:8];
    end
    if (be[2]) begin
      res[17:16] = data[17:16];
    end
    return res;
  endfunction : merge_lanes

  function automatic logic wr_to(input logic [4:0] off);
    return wr_hit && (req.address == off);
  endfunction : wr_to

  assign req = '{address: address, read: read, write: write,
                 writedata: writedata, byteenable: byteenable};

  avalon_slave_port u_port (
    .clk(clk),
    .rst(rst),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .access_pulse(access_pulse)
  );

  line_sampler u_sampler (
    .clk(clk),
    .rst(rst),
    .lines_in(line_in),
    .rise_out(rise_det),
    .fall_out(fall_det)
  );

  assign wr_hit = access_pulse && req.write;
  assign rd_hit = access_pulse && req.read;

  assign nxt_rise = merge_lanes(rise_sel_ff, req.writedata, req.byteenable);
  assign nxt_fall = merge_lanes(fall_sel_ff, req.writedata, req.byteenable);

  // Lines whose edge sensitivity is being changed in this cycle
  always_comb begin
    sens_chg = '0;
    if (wr_to(`OFF_RISE_SEL)) begin
      sens_chg = nxt_rise ^ rise_sel_ff;
    end
    if (wr_to(`OFF_FALL_SEL)) begin
      sens_chg = nxt_fall ^ fall_sel_ff;
    end
  end

  // Either selected direction arms a trigger
  assign hw_trig = (rise_det & rise_sel_ff) |
                   (fall_det & fall_sel_ff);

  // Software trigger only fires on a zero to one write
  always_comb begin
    sw_set = '0;
    if (wr_to(`OFF_SW_TRIG)) begin
      sw_set = merge_lanes(sw_trig_ff, req.writedata, req.byteenable) &
               ~sw_trig_ff;
    end
  end

  always_comb begin
    pend_clr = sens_chg;
    if (wr_to(`OFF_PENDING)) begin
      pend_clr = sens_chg | merge_lanes('0, req.writedata,
                                        req.byteenable);
    end
  end

  // An edge on a line being reconfigured is dropped; new triggers win
  // over a write-one clear otherwise
  assign nxt_pending = ((pending_ff & ~pend_clr) | sw_set |
                        (hw_trig & ~sens_chg));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_ff <= `RST_LINES;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_mask_ff <= `RST_LINES;
      evt_mask_ff <= `RST_LINES;
      rise_sel_ff <= `RST_LINES;
      fall_sel_ff <= `RST_LINES;
    end else begin
      if (wr_to(`OFF_INT_MASK)) begin
        int_mask_ff <= merge_lanes(int_mask_ff, req.writedata,
                                   req.byteenable);
      end
      if (wr_to(`OFF_EVT_MASK)) begin
        evt_mask_ff <= merge_lanes(evt_mask_ff, req.writedata,
                                   req.byteenable);
      end
      if (wr_to(`OFF_RISE_SEL)) begin
        rise_sel_ff <= nxt_rise;
      end
      if (wr_to(`OFF_FALL_SEL)) begin
        fall_sel_ff <= nxt_fall;
      end
    end
  end

  // Software trigger bits follow pending clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_trig_ff <= `RST_LINES;
    end else begin
      sw_trig_ff <= (sw_trig_ff | sw_set) & ~(pend_clr & ~sw_set);
    end
  end

  // Per-line request outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_irq_ff <= `RST_LINES;
      event_ff <= `RST_LINES;
    end else begin
      // Software pending requires both masks
      line_irq_ff <= pending_ff & int_mask_ff &
                     (~sw_trig_ff | evt_mask_ff);
      event_ff <= (hw_trig | sw_set) & evt_mask_ff;
    end
  end

  assign line_irq = line_irq_ff;
  assign event_pulse = event_ff;

  // Summary status: sticky, write one to clear, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_ff <= `RST_STATUS;
      stat_mask_ff <= `RST_STATUS;
    end else begin
      if (wr_to(`OFF_IRQ_MASK) && req.byteenable[0]) begin
        stat_mask_ff <= req.writedata[1:0];
      end
      stat_ff[`STAT_PEND_BIT] <= |(nxt_pending & ~pending_ff & int_mask_ff) |
        (stat_ff[`STAT_PEND_BIT] & ~(wr_to(`OFF_IRQ_STATUS) &&
        req.byteenable[0] && req.writedata[`STAT_PEND_BIT]));
      stat_ff[`STAT_EDGE_BIT] <= |(rise_det | fall_det) |
        (stat_ff[`STAT_EDGE_BIT] & ~(wr_to(`OFF_IRQ_STATUS) &&
        req.byteenable[0] && req.writedata[`STAT_EDGE_BIT]));
    end
  end

  assign irq = |(stat_ff & stat_mask_ff);

  // Read mux; reserved bits and unmapped words read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_ff <= `UNMAPPED_DATA;
    end else if (read && !access_pulse) begin
      case (req.address)
        `OFF_INT_MASK: readdata_ff <= {14'h0000, int_mask_ff};
        `OFF_EVT_MASK: readdata_ff <= {14'h0000, evt_mask_ff};
        `OFF_RISE_SEL: readdata_ff <= {14'h0000, rise_sel_ff};
        `OFF_FALL_SEL: readdata_ff <= {14'h0000, fall_sel_ff};
        `OFF_SW_TRIG: readdata_ff <= {14'h0000, sw_trig_ff};
        `OFF_PENDING: readdata_ff <= {14'h0000, pending_ff};
        `OFF_IRQ_STATUS: readdata_ff <= {30'h00000000, stat_ff};
        `OFF_IRQ_MASK: readdata_ff <= {30'h00000000, stat_mask_ff};
        default: readdata_ff <= `UNMAPPED_DATA;
      endcase
    end
  end

  assign readdata = readdata_ff;
  logic unused_rd;
  assign unused_rd = rd_hit;
endmodule : edge_event_line_controller

/* verif/edge_event_line_controller_sva.sv */
// Port-level assertions for the edge event line controller
`timescale 1ns/1ps
module edge_event_line_controller_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire edge_event_pkg::lines_t line_in,
  input wire edge_event_pkg::lines_t line_irq,
  input wire edge_event_pkg::lines_t event_pulse,
  input wire logic irq
);
  logic [2:0] age_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since the last completed write, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_ff <= 3'h7;
    end else if (write && !waitrequest) begin
      age_ff <= 3'h0;
    end else if (age_ff != 3'h7) begin
      age_ff <= age_ff + 3'h1;
    end
  end
  sequence req_wait;
    (read || write) && waitrequest;
  endsequence
  sequence req_done;
    (read || write) && !waitrequest;
  endsequence
  a_wait_one_cycle: assert property (req_wait |=> !waitrequest)
    else $error("request waited more than one cycle");
  a_wait_again: assert property (
    req_done ##1 (read || write) |-> waitrequest)
    else $error("new request answered without a wait cycle");
  a_upper_zero: assert property (
    read && !waitrequest |-> readdata[31:18] == 14'h0)
    else $error("upper read bits not zero");
  a_read_hold: assert property (!read |-> $stable(readdata))
    else $error("read data changed without a read");
  a_reset_quiet: assert property (
    $fell(rst) |-> event_pulse == '0 && line_irq == '0)
    else $error("outputs active right after reset");
  a_event_cause: assert property (
    (event_pulse & ~($past(line_in, 3) ^ $past(line_in, 6))) != '0
    |-> age_ff < 3'h5)
    else $error("event pulse without edge or write");
  a_irq_rise_cause: assert property (
    (line_irq & ~$past(line_irq) &
     ~($past(line_in, 3) ^ $past(line_in, 6))) != '0 |-> age_ff < 3'h5)
    else $error("line request rose without cause");
  a_irq_fall_cause: assert property (
    (~line_irq & $past(line_irq)) != '0 |-> age_ff < 3'h5)
    else $error("line request fell without a write");
endmodule : edge_event_line_controller_sva
bind edge_event_line_controller edge_event_line_controller_sva sva_u (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .line_in(line_in), .line_irq(line_irq),
  .event_pulse(event_pulse), .irq(irq));

/* verif/line_side_model.sv */
// Far side model: external input lines and event sink
`timescale 1ns/1ps
module line_side_model (
  input wire logic clk,
  input wire logic rst,
  input wire edge_event_pkg::lines_t level_req,
  input wire edge_event_pkg::lines_t event_pulse,
  output edge_event_pkg::lines_t line_out,
  output logic [7:0] pulse_count
);
  edge_event_pkg::lines_t lvl_ff = '0;
  // Lines move only just after an edge, so they never glitch
  always @(posedge clk) begin
    lvl_ff <= level_req;
  end
  assign line_out = lvl_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_count <= 8'h00;
    end else begin
      pulse_count <= pulse_count + 8'($countones(event_pulse));
    end
  end
endmodule : line_side_model

/* verif/edge_event_line_controller_tb.sv */
// Self-checking testbench for the edge event line controller
`timescale 1ns/1ps
`include "edge_event_defs.svh"
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  err_count++; $display("Error %0t: got %h expected %h", $time, got, exp); \
  end end
module edge_event_line_controller_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic [7:0] pulse_count;
  edge_event_pkg::lines_t line_in, line_irq, event_pulse;
  edge_event_pkg::lines_t level_req = 18'h0;
  int err_count = 0;
  int compares = 0;
  always #10 clk = ~clk;
  edge_event_line_controller dut_u (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .line_in(line_in), .line_irq(line_irq), .event_pulse(event_pulse),
    .irq(irq));
  line_side_model model_u (.clk(clk), .rst(rst), .level_req(level_req),
    .event_pulse(event_pulse), .line_out(line_in), .pulse_count(pulse_count));
  // Request holds until the rising edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHECK(q, e)
  endtask : rd
  task automatic drive(input edge_event_pkg::lines_t v);
    level_req <= v;
    repeat (8) @(posedge clk);
  endtask : drive
  task automatic out(input edge_event_pkg::lines_t e_irq,
      input logic [7:0] e_cnt, input logic e_int);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHECK(line_irq, e_irq)
    `CHECK(pulse_count, e_cnt)
    `CHECK(irq, e_int)
  endtask : out
  task automatic test_regs();
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), 32'h0);
    end
    wr(`OFF_INT_MASK, 32'hFFFFFFFF);
    rd(`OFF_INT_MASK, 32'h0003FFFF);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_edges();
    wr(`OFF_EVT_MASK, 32'h7);
    wr(`OFF_RISE_SEL, 32'h5);
    wr(`OFF_FALL_SEL, 32'h6);
    drive(18'h7);
    rd(`OFF_PENDING, 32'h5);
    out(18'h5, 8'h02, 1'b0);
    drive(18'h0);
    rd(`OFF_PENDING, 32'h7);
    out(18'h7, 8'h04, 1'b0);
    wr(`OFF_PENDING, 32'h7);
    rd(`OFF_PENDING, 32'h0);
    $display("test_edges done");
  endtask : test_edges
  task automatic test_cfg();
    wr(`OFF_INT_MASK, 32'h1);
    wr(`OFF_EVT_MASK, 32'h0);
    drive(18'h5);
    out(18'h1, 8'h04, 1'b0);
    wr(`OFF_RISE_SEL, 32'h4);
    rd(`OFF_PENDING, 32'h4);
    wr(`OFF_PENDING, 32'h4);
    $display("test_cfg done");
  endtask : test_cfg
  task automatic test_sw();
    wr(`OFF_INT_MASK, 32'h8);
    wr(`OFF_SW_TRIG, 32'h8);
    rd(`OFF_PENDING, 32'h8);
    out(18'h0, 8'h04, 1'b0);
    wr(`OFF_EVT_MASK, 32'h8);
    out(18'h8, 8'h04, 1'b0);
    wr(`OFF_PENDING, 32'h0);
    rd(`OFF_PENDING, 32'h8);
    wr(`OFF_PENDING, 32'h8);
    rd(`OFF_SW_TRIG, 32'h0);
    $display("test_sw done");
  endtask : test_sw
  task automatic test_irq();
    wr(`OFF_IRQ_STATUS, 32'h3);
    wr(`OFF_IRQ_MASK, 32'h1);
    wr(`OFF_INT_MASK, 32'h1);
    wr(`OFF_FALL_SEL, 32'h7);
    drive(18'h4);
    out(18'h1, 8'h04, 1'b1);
    rd(`OFF_IRQ_STATUS, 32'h3);
    wr(`OFF_IRQ_MASK, 32'h0);
    out(18'h1, 8'h04, 1'b0);
    wr(`OFF_IRQ_STATUS, 32'h3);
    wr(`OFF_IRQ_MASK, 32'h1);
    out(18'h1, 8'h04, 1'b0);
    rd(`OFF_IRQ_STATUS, 32'h0);
    $display("test_irq done");
  endtask : test_irq
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_edges();
    test_cfg();
    test_sw();
    test_irq();
    report_and_stop();
  end
endmodule : edge_event_line_controller_tb
